// ---- design/tis_pkg.sv ----
// Constants and types for the timer interrupt enable and status block
`default_nettype none
package tis_pkg;
  localparam int TIS_NCH = 5;
  // Reset values
  localparam logic [7:0] TIS_EN_RST = 8'h40;
  localparam logic [7:0] TIS_ST_RST = 8'hC0;
  localparam logic [7:0] TIS_ST_ONES = 8'h40;
  // Field positions
  localparam int TIS_B_ADC = 7;
  localparam int TIS_B_DIR = 7;
  localparam int TIS_B_RSV = 6;
  localparam int TIS_B_UDF = 5;
  localparam int TIS_B_OVF = 4;
  localparam int TIS_B_D = 3;
  localparam int TIS_B_C = 2;
  localparam int TIS_B_B = 1;
  localparam int TIS_B_A = 0;
  localparam int TIS_FW = 6;
  // Per-channel writable enable bits, forced ones, implemented flags
  localparam logic [7:0] TIS_EN_WMASK [TIS_NCH] =
    '{8'h9F, 8'hB3, 8'hB3, 8'h9F, 8'h9F};
  localparam logic [7:0] TIS_EN_ONES [TIS_NCH] =
    '{8'h40, 8'h4C, 8'h4C, 8'h40, 8'h40};
  localparam logic [5:0] TIS_ST_FMASK [TIS_NCH] =
    '{6'h1F, 6'h33, 6'h33, 6'h1F, 6'h1F};
  localparam logic [4:0] TIS_HAS_DIR = 5'h1E;
  // Register map, byte addresses
  localparam logic [7:0] TIS_OFS_EN = 8'h00;
  localparam logic [7:0] TIS_OFS_ST = 8'h20;
  localparam logic [7:0] TIS_OFS_IRQ_ST = 8'h40;
  localparam logic [7:0] TIS_OFS_IRQ_MSK = 8'h44;
  // Event inputs from the counter logic, flag order matches the layout
  typedef struct packed {
    logic count_up;
    logic udf;
    logic ovf;
    logic cmp_d;
    logic cmp_c;
    logic cmp_b;
    logic cmp_a;
  } tis_evt_s;
  // Interrupt requests and transfer clears, same flag order
  typedef struct packed {
    logic udf;
    logic ovf;
    logic cmp_d;
    logic cmp_c;
    logic cmp_b;
    logic cmp_a;
  } tis_req_s;
  // Captured AHB address phase
  typedef struct packed {
    logic sel;
    logic wr;
    logic hi_ok;
    logic [7:0] addr;
  } tis_aphase_s;
endpackage : tis_pkg
`default_nettype wire

// ---- design/tis_top.sv ----
// Timer interrupt enable and event flag registers with AHB-Lite access
`default_nettype none
module tis_top
  import tis_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic manual_rst,
  input wire logic standby,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic hresp,
  output var logic [31:0] hrdata,
  // Timer events and transfer clears
  input wire tis_evt_s evt [TIS_NCH],
  input wire tis_req_s xfer_clr [TIS_NCH],
  // Requests
  output var tis_req_s irq_req [TIS_NCH],
  output var logic [TIS_NCH-1:0] adc_start,
  output var logic irq
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] en_view(int ch, logic [7:0] v);
    en_view = (v & TIS_EN_WMASK[ch]) | TIS_EN_ONES[ch];
  endfunction : en_view

  function automatic logic [7:0] st_view(int ch, logic [5:0] f, logic d);
    st_view = {d | ~TIS_HAS_DIR[ch], 1'b1, f & TIS_ST_FMASK[ch]};
  endfunction : st_view

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] en_q [TIS_NCH];
  logic [TIS_FW-1:0] fl_q [TIS_NCH];
  logic [TIS_FW-1:0] arm_q [TIS_NCH];
  logic [TIS_NCH-1:0] dir_q;
  tis_req_s req_q [TIS_NCH];
  logic [TIS_NCH-1:0] adc_q;
  logic [TIS_NCH-1:0] new_req;
  logic [TIS_NCH-1:0] ev_st_q;
  logic [TIS_NCH-1:0] ev_msk_q;
  logic irq_q;
  tis_aphase_s ap_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_val;

  // Bus phase tracking
  wire logic take = hsel & htrans[1] & hready;
  wire logic wr_go = ap_q.sel & ap_q.wr;
  // Reads take one wait state so a preceding write is already visible
  wire logic rd_go = ap_q.sel & ~ap_q.wr & ~hreadyout_q;
  wire logic [2:0] a_ch = ap_q.addr[4:2];
  wire logic ch_ok = ap_q.hi_ok && (a_ch < 3'(TIS_NCH))
    && (ap_q.addr[1:0] == 2'h0);
  wire logic hit_en = ch_ok && (ap_q.addr[7:5] == TIS_OFS_EN[7:5]);
  wire logic hit_st = ch_ok && (ap_q.addr[7:5] == TIS_OFS_ST[7:5]);
  wire logic hit_evst = ap_q.hi_ok && (ap_q.addr == TIS_OFS_IRQ_ST);
  wire logic hit_msk = ap_q.hi_ok && (ap_q.addr == TIS_OFS_IRQ_MSK);
  wire logic st_rst = sys_rst | standby;
  wire logic en_rst = sys_rst | manual_rst | standby;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ap_q <= '0;
    end else if (hready) begin
      ap_q <= {take, hwrite, haddr[31:8] == 24'h0, haddr[7:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= ~(take & ~hwrite);
    end
  end

  // Unmapped addresses read zero; writes there are dropped
  always_comb begin
    rd_val = 32'h0;
    if (hit_en) begin
      rd_val[7:0] = en_view(int'(a_ch), en_q[a_ch]);
    end else if (hit_st) begin
      rd_val[7:0] = st_view(int'(a_ch), fl_q[a_ch], dir_q[a_ch]);
    end else if (hit_evst) begin
      rd_val[TIS_NCH-1:0] = ev_st_q;
    end else if (hit_msk) begin
      rd_val[TIS_NCH-1:0] = ev_msk_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata_q <= 32'h0;
    end else if (rd_go) begin
      hrdata_q <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  for (genvar ch = 0; ch < TIS_NCH; ch++) begin : g_ch
    wire logic sel_c = (a_ch == 3'(ch));
    wire logic wr_en_c = wr_go & hit_en & sel_c;
    wire logic wr_st_c = wr_go & hit_st & sel_c;
    wire logic rd_st_c = rd_go & hit_st & sel_c;
    wire logic [TIS_FW-1:0] set_c = evt[ch][TIS_FW-1:0] & TIS_ST_FMASK[ch];
    wire logic [TIS_FW-1:0] clr_sw = wr_st_c ?
      (~hwdata[TIS_FW-1:0] & arm_q[ch]) : '0;
    wire logic [TIS_FW-1:0] clr_c = clr_sw | xfer_clr[ch];
    wire logic [TIS_FW-1:0] fl_d = (fl_q[ch] & ~clr_c) | set_c;
    wire logic [TIS_FW-1:0] arm_d =
      (rd_st_c ? (arm_q[ch] | fl_q[ch]) : arm_q[ch]) & fl_d;
    wire logic [7:0] en_d = wr_en_c ?
      ((hwdata[7:0] & TIS_EN_WMASK[ch]) | TIS_EN_RST) : en_q[ch];
    wire tis_req_s req_d = fl_q[ch] & en_q[ch][TIS_FW-1:0];
    // direction, fixed one on channel 0
    wire logic dir_d = TIS_HAS_DIR[ch] ? evt[ch].count_up : 1'b1;

    always_ff @(posedge clk) begin
      if (en_rst) begin
        en_q[ch] <= TIS_EN_RST;
      end else begin
        en_q[ch] <= en_d;
      end
    end

    always_ff @(posedge clk) begin
      if (st_rst) begin
        fl_q[ch] <= TIS_ST_RST[TIS_FW-1:0];
        arm_q[ch] <= '0;
        dir_q[ch] <= TIS_ST_RST[TIS_B_DIR];
      end else begin
        fl_q[ch] <= fl_d;
        arm_q[ch] <= arm_d;
        dir_q[ch] <= dir_d;
      end
    end

    // Requests fall on manual reset through the enables a cycle later
    always_ff @(posedge clk) begin
      if (st_rst) begin
        req_q[ch] <= '0;
        adc_q[ch] <= 1'b0;
      end else begin
        req_q[ch] <= req_d;
        adc_q[ch] <= en_q[ch][TIS_B_ADC] & evt[ch].cmp_a;
      end
    end

    assign new_req[ch] = |(req_d & ~req_q[ch]);
    assign irq_req[ch] = req_q[ch];

    a_en_reset_val: assert property (@(posedge clk)
      en_rst |=> en_q[ch] == TIS_EN_RST)
      else $error("enable register not at reset value");

    a_en_fixed_bits: assert property (@(posedge clk)
      disable iff (sys_rst)
      (en_q[ch] & ~TIS_EN_WMASK[ch]) == TIS_EN_RST)
      else $error("read-only enable bits changed");

    a_adc_gate: assert property (@(posedge clk)
      disable iff (sys_rst)
      !st_rst ##0 $stable(en_q[ch]) |=>
      adc_q[ch] == ($past(en_q[ch][TIS_B_ADC]) && $past(evt[ch].cmp_a)))
      else $error("ADC start not gated by enable");

    a_req_gate: assert property (@(posedge clk)
      disable iff (st_rst)
      (fl_q[ch][TIS_B_OVF] && en_q[ch][TIS_B_OVF]) ##1 !st_rst
      |-> req_q[ch].ovf)
      else $error("overflow request missing");

    a_flag_set: assert property (@(posedge clk)
      disable iff (st_rst)
      evt[ch].cmp_a ##1 !st_rst |-> fl_q[ch][TIS_B_A])
      else $error("compare A event lost");

    a_no_write_set: assert property (@(posedge clk)
      disable iff (st_rst)
      wr_st_c && set_c == '0 |=> (fl_q[ch] & ~$past(fl_q[ch])) == '0)
      else $error("write set a flag");

    a_clear_armed: assert property (@(posedge clk)
      disable iff (st_rst)
      fl_q[ch][TIS_B_A] && !arm_q[ch][TIS_B_A] && !xfer_clr[ch].cmp_a
      |=> fl_q[ch][TIS_B_A] || st_rst)
      else $error("flag cleared without prior read");

    a_manual_keep: assert property (@(posedge clk)
      disable iff (st_rst)
      manual_rst && !wr_st_c && xfer_clr[ch] == '0
      |=> (($past(fl_q[ch]) & ~fl_q[ch]) == '0) || st_rst)
      else $error("manual reset disturbed flags");

    a_dir_track: assert property (@(posedge clk)
      disable iff (st_rst)
      1'b1 ##1 !st_rst |-> dir_q[ch] ==
      (TIS_HAS_DIR[ch] ? $past(evt[ch].count_up) : 1'b1))
      else $error("direction bit wrong");
  end

  ////////////////////////////////////////////////////////////////////////
  // Summary interrupt: new request events, write one to clear
  wire logic [TIS_NCH-1:0] ev_clr = (wr_go & hit_evst) ?
    hwdata[TIS_NCH-1:0] : '0;

  always_ff @(posedge clk) begin
    if (st_rst) begin
      ev_st_q <= '0;
      ev_msk_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ev_st_q <= (ev_st_q & ~ev_clr) | new_req;
      ev_msk_q <= (wr_go & hit_msk) ? hwdata[TIS_NCH-1:0] : ev_msk_q;
      irq_q <= |(ev_st_q & ev_msk_q);
    end
  end

  a_bit6_reads: assert property (@(posedge clk)
    disable iff (sys_rst)
    rd_go && (hit_en || hit_st) |=> hrdata_q[TIS_B_RSV] && hreadyout_q)
    else $error("bit 6 did not read one");

  a_irq_level: assert property (@(posedge clk)
    disable iff (st_rst)
    1'b1 ##1 !st_rst |-> irq_q == $past(|(ev_st_q & ev_msk_q)))
    else $error("interrupt output wrong");

  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign adc_start = adc_q;
  assign irq = irq_q;
endmodule : tis_top
`default_nettype wire

// ---- test/tis_far.sv ----
// Far-side model: event source, transfer clears, converter trigger sink
`default_nettype none
module tis_far
  import tis_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic [2:0] ch,
  input wire logic [5:0] ev,
  input wire logic up,
  input wire logic go,
  input wire logic clr,
  // Block side
  output var tis_evt_s evt [TIS_NCH],
  output var tis_req_s xfer_clr [TIS_NCH],
  input wire logic [TIS_NCH-1:0] adc_start,
  output var int adc_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    adc_n = 0;
    for (int c = 0; c < TIS_NCH; c++) begin
      evt[c] = '0;
      xfer_clr[c] = '0;
    end
  end
  always @(posedge clk) begin
    for (int c = 0; c < TIS_NCH; c++) begin
      evt[c] <= (go && ch == c) ? {up, ev} : {up, 6'h00};
      xfer_clr[c] <= (clr && ch == c) ? ev : 6'h00;
    end
    adc_n <= adc_n + $countones(adc_start);
  end
endmodule : tis_far
`default_nettype wire

// ---- test/tis_top_bench.sv ----
// Self-checking bench for the timer interrupt enable and flag block
`default_nettype none
module tis_top_bench
  import tis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, manual_rst, standby, hwrite, hreadyout, hresp, irq;
  logic go, clr, up, rd_ph;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] ch;
  logic [5:0] ev;
  logic [7:0] d;
  logic [TIS_NCH-1:0] adc_start;
  tis_evt_s evt [TIS_NCH];
  tis_req_s xfer_clr [TIS_NCH];
  tis_req_s irq_req [TIS_NCH];
  logic [31:0] q [$];
  int fails, total_checks, adc_n, seed;
  tis_top dut_u (.clk(clk), .sys_rst(sys_rst), .manual_rst(manual_rst),
    .standby(standby), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt),
    .xfer_clr(xfer_clr), .irq_req(irq_req), .adc_start(adc_start),
    .irq(irq));
  tis_far far_u (.clk(clk), .ch(ch), .ev(ev), .up(up), .go(go), .clr(clr),
    .evt(evt), .xfer_clr(xfer_clr), .adc_start(adc_start), .adc_n(adc_n));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic wait_rdy();
    do @(posedge clk); while (hreadyout !== 1'h1);
  endtask : wait_rdy
  // Reads leave their expected word in the queue for the monitor
  task automatic acc(input int a, input logic w, input logic [31:0] v);
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= w;
    if (!w) q.push_back(v);
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= w ? v : 32'h0;
    wait_rdy();
  endtask : acc
  task automatic fire(input int c, input logic [5:0] e, input logic x);
    ch <= 3'(c);
    ev <= e;
    go <= !x;
    clr <= x;
    @(posedge clk);
    go <= 1'h0;
    clr <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : fire
  task automatic wrap_up();
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_ph && hreadyout) begin
      chk(q.pop_front(), hrdata);
      chk(32'h0, {31'h0, hresp});
    end
    if (hreadyout) rd_ph <= htrans[1] && !hwrite;
  end
  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    wrap_up();
  end
  initial begin
    {sys_rst, manual_rst, standby, hwrite, go, clr, rd_ph} = 7'h40;
    {haddr, hwdata, htrans, ch, ev} = '0;
    up = 1'h1;
    fails = 0;
    total_checks = 0;
    seed = 11;
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    for (int c = 0; c < TIS_NCH; c++) begin
      acc(c * 4, 1'h0, TIS_EN_RST | TIS_EN_ONES[c]);
      acc(32 + c * 4, 1'h1, 32'hFF);
      acc(32 + c * 4, 1'h0, TIS_ST_RST);
      d = 8'($random(seed));
      acc(c * 4, 1'h1, d);
      acc(c * 4, 1'h0, (d & TIS_EN_WMASK[c]) | TIS_EN_ONES[c]);
      acc(c * 4, 1'h1, 32'h7F);
      fire(c, 6'h3F, 1'h0);
      chk({26'h0, TIS_ST_FMASK[c]}, {26'h0, irq_req[c]});
      // Zero write before any read of one must not clear
      acc(32 + c * 4, 1'h1, 32'hC0);
      acc(32 + c * 4, 1'h0, {24'h0, 2'h3, TIS_ST_FMASK[c]});
      acc(32 + c * 4, 1'h1, 32'hC0);
      acc(32 + c * 4, 1'h0, TIS_ST_RST);
      // Request register trails the flag clear by one edge
      repeat (2) @(posedge clk);
      chk(32'h0, {26'h0, irq_req[c]});
      acc(c * 4, 1'h1, 32'hFF);
      fire(c, 6'h01, 1'h0);
      chk(32'(c + 1), 32'(adc_n));
      fire(c, 6'h01, 1'h1);
      acc(32 + c * 4, 1'h0, TIS_ST_RST);
    end
    chk(32'h0, {31'h0, irq});
    acc(68, 1'h1, 32'h1F);
    repeat (2) @(posedge clk);
    chk(32'h1, {31'h0, irq});
    acc(64, 1'h0, 32'h1F);
    acc(64, 1'h1, 32'h1F);
    repeat (2) @(posedge clk);
    chk(32'h0, {31'h0, irq});
    up <= 1'h0;
    fire(0, 6'h02, 1'h0);
    acc(32, 1'h0, 32'hC2);
    acc(36, 1'h0, 32'h40);
    manual_rst <= 1'h1;
    @(posedge clk);
    manual_rst <= 1'h0;
    acc(0, 1'h0, 32'h40);
    acc(32, 1'h0, 32'hC2);
    standby <= 1'h1;
    @(posedge clk);
    standby <= 1'h0;
    acc(32, 1'h0, 32'hC0);
    acc(128, 1'h0, 32'h0);
    wrap_up();
  end
endmodule : tis_top_bench
`default_nettype wire
